// [eeprom_ctl_pkg.sv]
package eeprom_ctl_pkg;

	// Array geometry.
	localparam int ADDR_W = 11;
	localparam int DATA_W = 8;
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	// Clock rate and the programming pulse width.
	localparam int CLK_PERIOD_PS = 5000;
	localparam int PULSE_MS = 50;
	// Divide first: the product of milliseconds and picoseconds overflows a 32-bit int.
	localparam int PULSE_CYCLES = PULSE_MS * (1000000000 / CLK_PERIOD_PS);

	// Guard time around the pulse so that pins settle before and after it.
	localparam int SETTLE_NS = 100;
	localparam int SETTLE_CYCLES = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Read access time of the memory, a longest time.
	localparam int ACCESS_NS = 250;
	localparam int ACCESS_CYCLES = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Command codes on the user port.
	localparam logic [2:0] CMD_READ = 3'h0;
	localparam logic [2:0] CMD_BYTE_ERASE = 3'h1;
	localparam logic [2:0] CMD_BYTE_WRITE = 3'h2;
	localparam logic [2:0] CMD_CHIP_ERASE = 3'h3;

	// Values after reset.
	localparam logic [31:0] CNT_RESET = 32'h0;

endpackage : eeprom_ctl_pkg

// [eeprom_mode_ctl.sv]
`timescale 1ns/1ps
// Operation
// - Byte erase: select low, enable high, data all ones, supply raised.
// - Byte write: select low, enable high, byte on data, supply raised.
// - Chip erase: select low, enable elevated, data all ones, supply pulsed.
// - One 50 ms pulse per erase; erase before write; one byte per write pulse.
// - Erase and write use the same decoded select as reads.
module eeprom_mode_ctl
	import eeprom_ctl_pkg::*;
#(
	parameter int PULSE_LEN = PULSE_CYCLES
)
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_req_valid,
	output logic o_req_ready,
	input wire logic [2:0] i_req_cmd,
	input wire logic [ADDR_W-1:0] i_req_addr,
	input wire logic [DATA_W-1:0] i_req_data,
	input wire logic i_dev_sel,
	output logic o_done,
	output logic [DATA_W-1:0] o_rd_data,
	output logic o_chip_sel_n,
	output logic o_out_en_n,
	output logic o_oe_high_volt,
	output logic o_prog_volt,
	output logic [ADDR_W-1:0] o_addr,
	output logic [DATA_W-1:0] o_data_out,
	output logic o_data_oe_n,
	input wire logic [DATA_W-1:0] i_data_in
);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_READ = 3'b001,
		ST_SETUP = 3'b010,
		ST_PULSE = 3'b011,
		ST_HOLD = 3'b100
	} state_e;

	state_e state_reg, state_next;
	logic [31:0] cnt_reg, cnt_next;
	logic [2:0] cmd_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [DATA_W-1:0] data_reg;
	logic [DATA_W-1:0] rd_reg;
	logic sel_reg;
	logic done_reg;
	logic [DATA_W-1:0] din_s1_reg, din_s2_reg;

	// Decoded command classes.
	// Reads need no class wire of their own, since only the read state lowers output enable.
	wire is_chip_erase = (cmd_reg == CMD_CHIP_ERASE);
	wire is_erase = (cmd_reg == CMD_BYTE_ERASE) || is_chip_erase;
	wire take = i_req_valid && (state_reg == ST_IDLE);
	wire cnt_zero = (cnt_reg == CNT_RESET);
	wire in_prog = (state_reg == ST_SETUP) || (state_reg == ST_PULSE) || (state_reg == ST_HOLD);

	assign o_req_ready = (state_reg == ST_IDLE);
	assign o_done = done_reg;
	assign o_rd_data = rd_reg;

	// Pin levels come straight from held registers, so nothing moves mid-pulse.
	assign o_chip_sel_n = ~sel_reg;
	assign o_out_en_n = ~((state_reg == ST_READ) && sel_reg);
	assign o_oe_high_volt = in_prog && is_chip_erase;
	assign o_prog_volt = (state_reg == ST_PULSE);
	assign o_addr = addr_reg;
	assign o_data_out = is_erase ? ERASED_BYTE : data_reg;
	assign o_data_oe_n = ~in_prog;

	// Sequencer. The setup and hold guards keep the supply at its normal level
	// whenever select or data change, and a read can only start from idle.
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			ST_IDLE:
			begin
				if (i_req_valid)
				begin
					if (i_req_cmd == CMD_READ)
					begin
						state_next = ST_READ;
						cnt_next = 32'(ACCESS_CYCLES + 2);
					end
					else
					begin
						state_next = ST_SETUP;
						cnt_next = 32'(SETTLE_CYCLES);
					end
				end
			end
			ST_READ:
			begin
				if (cnt_zero)
					state_next = ST_IDLE;
				else
					cnt_next = cnt_reg - 32'h1;
			end
			ST_SETUP:
			begin
				if (cnt_zero)
				begin
					state_next = ST_PULSE;
					cnt_next = 32'(PULSE_LEN - 1);
				end
				else
					cnt_next = cnt_reg - 32'h1;
			end
			ST_PULSE:
			begin
				if (cnt_zero)
				begin
					state_next = ST_HOLD;
					cnt_next = 32'(SETTLE_CYCLES);
				end
				else
					cnt_next = cnt_reg - 32'h1;
			end
			ST_HOLD:
			begin
				if (cnt_zero)
					state_next = ST_IDLE;
				else
					cnt_next = cnt_reg - 32'h1;
			end
			default:
			begin
				state_next = ST_IDLE;
				cnt_next = CNT_RESET;
			end
		endcase
	end

	// State, counter and the captured request.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= CNT_RESET;
			cmd_reg <= CMD_READ;
			addr_reg <= '0;
			data_reg <= '0;
			sel_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			if (take)
			begin
				cmd_reg <= i_req_cmd;
				addr_reg <= i_req_addr;
				data_reg <= i_req_data;
				sel_reg <= i_dev_sel;
			end
			else if (state_next == ST_IDLE)
				sel_reg <= 1'b0;
		end
	end

	// Data pins are asynchronous to our clock, so they pass two flops.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			din_s1_reg <= '0;
			din_s2_reg <= '0;
			rd_reg <= '0;
			done_reg <= 1'b0;
		end
		else
		begin
			din_s1_reg <= i_data_in;
			din_s2_reg <= din_s1_reg;
			done_reg <= (state_reg != ST_IDLE) && (state_next == ST_IDLE);
			if ((state_reg == ST_READ) && cnt_zero)
				rd_reg <= din_s2_reg;
		end
	end

	a_pulse_normal_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!o_out_en_n |-> !o_prog_volt && !o_oe_high_volt)
		else $error("Output enable low while programming voltage is raised.");

	a_pulse_stable_pins: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_prog_volt && $past(o_prog_volt) |-> $stable(o_addr) && $stable(o_data_out) && $stable(o_chip_sel_n))
		else $error("Address, data or select moved during programming pulse.");

	a_erase_data_ones: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_prog_volt && is_erase |-> o_data_out == ERASED_BYTE && !o_data_oe_n)
		else $error("Erase pulse without all-ones data.");

	a_chip_erase_oe: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_oe_high_volt |-> is_chip_erase && o_out_en_n)
		else $error("Elevated output enable outside chip erase.");

	a_write_oe_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_prog_volt |-> o_out_en_n && !o_data_oe_n)
		else $error("Write pulse with output enable low or data not driven.");

	a_pulse_start_width: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$rose(o_prog_volt) |-> o_prog_volt [*8])
		else $error("Programming pulse ended too early.");

	a_read_needs_sel: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!o_out_en_n |-> !o_chip_sel_n)
		else $error("Output enable low while deselected.");

	a_pulse_one_shot: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$fell(o_prog_volt) |-> !o_prog_volt [*2] ##1 (state_reg == ST_HOLD || state_reg == ST_IDLE))
		else $error("Second pulse issued within one request.");

endmodule : eeprom_mode_ctl

// [eeprom_array_model.sv]
`timescale 1ns/1ps
module eeprom_array_model
	import eeprom_ctl_pkg::*;
(
	input wire logic i_chip_sel_n,
	input wire logic i_out_en_n,
	input wire logic i_oe_high_volt,
	input wire logic i_prog_volt,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic i_data_oe_n,
	input wire logic [DATA_W-1:0] i_data,
	output logic [DATA_W-1:0] o_data
);
	logic [DATA_W-1:0] mem_reg [0:2**ADDR_W-1];
	logic [DATA_W-1:0] last_reg = 8'h00;
	wire drive = !i_chip_sel_n && !i_out_en_n && !i_prog_volt;
	// Undriven data pins read as the inverse, so a pulse with the bus released corrupts the cell.
	wire [DATA_W-1:0] pin_data = i_data_oe_n ? ~i_data : i_data;
	// Cells change at the end of the pulse; a write other than all ones only clears bits, so a missed erase shows.
	always @(negedge i_prog_volt)
	begin
		if (!i_chip_sel_n)
		begin
			if (i_oe_high_volt)
				foreach (mem_reg[k])
					mem_reg[k] = ERASED_BYTE;
			else if (pin_data == ERASED_BYTE)
				mem_reg[i_addr] = ERASED_BYTE;
			else
				mem_reg[i_addr] = mem_reg[i_addr] & pin_data;
		end
	end
	// A floating bus shows the inverse of the last byte so stale data never passes.
	always @*
	begin
		if (drive)
			last_reg = mem_reg[i_addr];
	end
	assign o_data = drive ? mem_reg[i_addr] : ~last_reg;
endmodule : eeprom_array_model

// [eeprom_mode_select_control_tb_top.sv]
`timescale 1ns/1ps
module eeprom_mode_select_control_tb_top;
	import eeprom_ctl_pkg::*;
	logic i_clk = 0, i_rst_n = 0, vld = 0, sel = 0;
	logic [2:0] cmd = 3'h0;
	logic [10:0] adr = 11'h000;
	logic [7:0] wd = 8'h00;
	wire rdy, done, cs_n, oe_n, oe_hv, pv, d_oe_n;
	wire [7:0] rd, dout, din;
	wire [10:0] pa;
	int num_errors = 0, samples_checked = 0;
	always #2.5 i_clk = ~i_clk;
	eeprom_mode_ctl #(.PULSE_LEN(20)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req_valid(vld),
		.o_req_ready(rdy), .i_req_cmd(cmd), .i_req_addr(adr), .i_req_data(wd), .i_dev_sel(sel),
		.o_done(done), .o_rd_data(rd), .o_chip_sel_n(cs_n), .o_out_en_n(oe_n), .o_oe_high_volt(oe_hv),
		.o_prog_volt(pv), .o_addr(pa), .o_data_out(dout), .o_data_oe_n(d_oe_n), .i_data_in(din));
	eeprom_array_model mem (.i_chip_sel_n(cs_n), .i_out_en_n(oe_n), .i_oe_high_volt(oe_hv),
		.i_prog_volt(pv), .i_addr(pa), .i_data_oe_n(d_oe_n), .i_data(dout), .o_data(din));
	task summarize;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	task check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// One request, held for one clock edge, then a bounded wait for completion.
	task op(input logic [2:0] c, input logic [10:0] a, input logic [7:0] d, input logic s);
		int n;
		n = 0;
		check({7'h0, rdy}, 8'h01);
		vld = 1;
		cmd = c;
		adr = a;
		wd = d;
		sel = s;
		@(posedge i_clk);
		#1 vld = 0;
		check({7'h0, rdy}, 8'h00);
		check({7'h0, cs_n}, {7'h0, ~s});
		while (done !== 1'b1 && n < 300)
		begin
			@(posedge i_clk);
			#1 n++;
		end
		check({7'h0, done}, 8'h01);
	endtask : op
	task t_chip_erase;
		op(CMD_CHIP_ERASE, 11'h000, 8'hff, 1);
		op(CMD_READ, 11'h000, 8'h00, 1);
		check(rd, 8'hff);
		op(CMD_READ, 11'h7ff, 8'h00, 1);
		check(rd, 8'hff);
	endtask : t_chip_erase
	task t_program;
		op(CMD_BYTE_WRITE, 11'h005, 8'h0f, 1);
		op(CMD_BYTE_ERASE, 11'h005, 8'hff, 1);
		op(CMD_BYTE_WRITE, 11'h005, 8'ha5, 1);
		op(CMD_READ, 11'h005, 8'h00, 1);
		check(rd, 8'ha5);
		op(CMD_READ, 11'h006, 8'h00, 1);
		check(rd, 8'hff);
	endtask : t_program
	task t_inhibit;
		op(CMD_BYTE_WRITE, 11'h005, 8'h00, 0);
		op(CMD_CHIP_ERASE, 11'h000, 8'hff, 0);
		op(CMD_READ, 11'h005, 8'h00, 1);
		check(rd, 8'ha5);
		check({7'h0, cs_n}, 8'h01);
	endtask : t_inhibit
	initial
	begin
		#100000;
		num_errors++;
		summarize();
	end
	initial
	begin
		repeat (12) @(posedge i_clk);
		#1 i_rst_n = 1;
		t_chip_erase();
		t_program();
		t_inhibit();
		summarize();
	end
endmodule : eeprom_mode_select_control_tb_top
